/* pcc_cal_eng.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// calibration engine model
module pcc_cal_eng #(
	parameter int DLY = 60
) (
	input wire logic sys_clk,
	input wire logic cal_active,
	input wire logic fail_req,
	input wire logic [7:0] resp_req,
	output logic cal_done = 1'h0,
	output logic cal_fail = 1'h0,
	output logic [7:0] resp_param = 8'h00
);
	int cnt = 0;
	wire fin = cal_active && cnt == DLY;
	// results only valid with the pulse; scrambled otherwise
	always @(posedge sys_clk) begin
		cnt <= cal_active ? cnt + 1 : 0;
		cal_done <= fin;
		cal_fail <= fin ? fail_req : !cal_fail;
		resp_param <= fin ? resp_req : ~resp_param;
	end
endmodule
`default_nettype wire

/* pcc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// checker
module pcc_chk import pcc_pkg::*; (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic recalibrate_button,
	input wire logic cal_done,
	input wire logic air_to_close,
	input wire logic cal_active,
	input wire logic [15:0] target_pos,
	input wire logic led_yellow
);
	logic oos_q;
	logic [2:0] since_evt;
	wire wr_done = psel && penable && pready && pwrite;
	wire mapped = paddr == ADDR_CTRL || paddr == ADDR_CFG || paddr == ADDR_CMD
		|| paddr == ADDR_STAT || paddr == ADDR_SW
		|| (paddr >= ADDR_CUST && paddr <= ADDR_CUST_END && paddr[1:0] == 2'h0);
	// host writes move config too, so allow a short window after either event
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			oos_q <= 1'h0;
			since_evt <= 3'h7;
		end else begin
			if (wr_done && paddr == ADDR_CTRL)
				oos_q <= pwdata[CTRL_OOS];
			if (cal_done || (wr_done && paddr == ADDR_CFG))
				since_evt <= 3'h0;
			else if (since_evt != 3'h7)
				since_evt <= since_evt + 3'h1;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	chk_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after one wait");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_unmapped_err: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr wrong");
	chk_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("write returned data");
	chk_cmd_clamp: assert property (target_pos <= CMD_MAX)
		else $error("target above full scale");
	chk_cfg_hold: assert property ($changed(air_to_close) |-> since_evt <= 3'h4)
		else $error("config moved without commit");
	chk_oos_start: assert property ($rose(cal_active) |-> oos_q)
		else $error("calibration outside service off");
	chk_cal_end: assert property (cal_done && cal_active && !recalibrate_button
		|-> ##[1:3] !cal_active)
		else $error("calibration did not end");
	chk_cal_lamp: assert property ($rose(cal_active) |-> ##[0:2] led_yellow)
		else $error("no calibrating lamp");
	cover property ($rose(cal_active));
	cover property (pready && pslverr);
	cover property (cal_done && cal_active);
endmodule
bind pcc_top pcc_chk u_chk (.sys_clk, .arst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
	.prdata, .pready, .pslverr, .recalibrate_button, .cal_done, .air_to_close, .cal_active,
	.target_pos, .led_yellow);
`default_nettype wire

/* pcc_pkg.sv */
package pcc_pkg;
	// ==========================================
	// timing
	localparam int CLK_HZ = 200_000_000;
	localparam int HOLD_MS = 3000;
	localparam int HOLD_CYC_DEF = int'((longint'(HOLD_MS) * CLK_HZ) / 1000);
	// ==========================================
	// register offsets
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_CFG = 12'h004;
	localparam logic [11:0] ADDR_CMD = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h00C;
	localparam logic [11:0] ADDR_SW = 12'h010;
	localparam logic [11:0] ADDR_CUST = 12'h040;
	localparam logic [11:0] ADDR_CUST_END = 12'h090;
	// ==========================================
	// fields; switch bank and config share bit positions
	localparam int CTRL_OOS = 0;
	localparam int CTRL_CAL = 1;
	localparam int CFG_ATC = 0;
	localparam int CFG_OTHER = 1;
	localparam int CFG_AUTO = 2;
	localparam int CFG_STAB = 3;
	localparam int CFG_JOG = 4;
	localparam int CFG_FF = 6;
	localparam int CFG_CURVE = 8;
	localparam int STAT_GAIN = 16;
	localparam int STAT_CAL = 26;
	localparam int STAT_OVR = 27;
	localparam int STAT_FAIL = 28;
	localparam logic [7:0] SW_RST = 8'h00;
	// ==========================================
	// curves, hundredths of a percent
	localparam int NPTS = 21;
	localparam logic [15:0] CMD_MAX = 16'h2710;
	localparam logic [15:0] PT_STEP = 16'h01F4;
	typedef enum logic [1:0] {
		CRV_EQP = 2'b00,
		CRV_QO = 2'b01,
		CRV_CUST = 2'b10,
		CRV_LIN = 2'b11
	} pcc_curve_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HOLD = 3'b001,
		ST_CALH = 3'b010,
		ST_CAL = 3'b011,
		ST_REL = 3'b100
	} pcc_state_e;
	// index 0 is the rightmost entry
	localparam logic [20:0][15:0] EQP_TBL = {16'd10000, 16'd8103, 16'd6784, 16'd5671,
		16'd4732, 16'd3940, 16'd3271, 16'd2708, 16'd2232, 16'd1831, 16'd1492, 16'd1207,
		16'd966, 16'd763, 16'd591, 16'd447, 16'd325, 16'd222, 16'd135, 16'd62, 16'd0};
	localparam logic [20:0][15:0] QO_TBL = {16'd10000, 16'd9950, 16'd9900, 16'd9850,
		16'd9800, 16'd9750, 16'd9700, 16'd9650, 16'd9600, 16'd9550, 16'd9480, 16'd9420,
		16'd9340, 16'd9200, 16'd9000, 16'd8430, 16'd7400, 16'd5640, 16'd3760, 16'd1880, 16'd0};
	localparam logic [20:0][15:0] CUST_RST = {16'd10000, 16'd9445, 16'd8889, 16'd8550,
		16'd8211, 16'd7817, 16'd7423, 16'd7027, 16'd6631, 16'd6239, 16'd5847, 16'd5440,
		16'd5034, 16'd4542, 16'd4051, 16'd3531, 16'd3011, 16'd2317, 16'd1624, 16'd866, 16'd0};
	// ==========================================
	// gain sets, selector A=0 .. H=7; scale is eighths, E=8/8
	localparam logic [7:0][3:0] AUTO_SCALE = {4'hE, 4'hC, 4'hA, 4'h8,
		4'h7, 4'h6, 4'h5, 4'h4};
	localparam logic [7:0][9:0] PRESET_GAIN = {10'h200, 10'h180, 10'h120, 10'h0C0,
		10'h090, 10'h060, 10'h040, 10'h020};
endpackage

/* pcc_top.sv */
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pcc_top import pcc_pkg::*; #(
	parameter int HOLD_CYC = HOLD_CYC_DEF
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] cfg_switch_pin,
	input wire logic [2:0] gain_select_pin,
	input wire logic recalibrate_button,
	input wire logic cal_done,
	input wire logic cal_fail,
	input wire logic [7:0] resp_param,
	output logic air_to_close,
	output logic high_friction_mode,
	output logic cal_active,
	output logic cal_jog,
	output logic [1:0] ff_option,
	output logic [15:0] target_pos,
	output logic [9:0] control_gain,
	output logic led_green,
	output logic led_yellow,
	output logic led_red
);
	// ==========================================
	// reset release
	logic rst_q1, rst_n;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// ==========================================
	// pin synchronisers: value moves only when stages two and three agree
	logic [11:0] pin_s1, pin_s2, pin_s3, pin_v;
	wire [11:0] pin_raw = {recalibrate_button, gain_select_pin, cfg_switch_pin};
	wire [11:0] pin_agree = ~(pin_s2 ^ pin_s3);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 12'h000;
			pin_s2 <= 12'h000;
			pin_s3 <= 12'h000;
			pin_v <= 12'h000;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_v <= (pin_v & ~pin_agree) | (pin_s2 & pin_agree);
		end
	end
	wire [7:0] sw_now = pin_v[7:0];
	wire [2:0] gain_sel = pin_v[10:8];
	wire btn = pin_v[11];
	logic btn_d;
	wire btn_rise = btn & ~btn_d;

	// ==========================================
	// state
	pcc_state_e state;
	logic [31:0] hold_cnt;
	logic [7:0] act_sw, pend_sw;
	logic [1:0] curve_sel;
	logic host_ovr, from_host, out_of_service_mode, fail_q;
	logic [15:0] cmd;
	logic [7:0] resp_q;
	logic [20:0][15:0] cx, cy;

	// ==========================================
	// apb decode; answer one cycle into the access phase
	wire acc = psel & penable & pready;
	wire wr = acc & pwrite;
	wire hit_ctrl = paddr == ADDR_CTRL;
	wire hit_cfg = paddr == ADDR_CFG;
	wire hit_cmd = paddr == ADDR_CMD;
	wire hit_stat = paddr == ADDR_STAT;
	wire hit_sw = paddr == ADDR_SW;
	wire hit_cust = paddr >= ADDR_CUST && paddr <= ADDR_CUST_END && paddr[1:0] == 2'b00;
	wire [11:0] cust_off = paddr - ADDR_CUST;
	wire [4:0] cidx = cust_off[6:2];
	wire cal_req = wr & hit_ctrl & pwdata[CTRL_CAL];
	logic [31:0] rd_n;
	logic err_n;
	always_comb begin
		rd_n = 32'h0000_0000;
		err_n = 1'b0;
		if (hit_ctrl) begin
			rd_n[CTRL_OOS] = out_of_service_mode;
		end else if (hit_cfg) begin
			rd_n[7:0] = act_sw;
			rd_n[CFG_CURVE+:2] = curve_sel;
		end else if (hit_cmd) begin
			rd_n[15:0] = cmd;
		end else if (hit_stat) begin
			rd_n[15:0] = target_pos;
			rd_n[STAT_GAIN+:10] = control_gain;
			rd_n[STAT_CAL] = cal_active;
			rd_n[STAT_OVR] = host_ovr;
			rd_n[STAT_FAIL] = fail_q;
		end else if (hit_sw) begin
			rd_n[10:0] = pin_v[10:0];
		end else if (hit_cust) begin
			rd_n = {cx[cidx], cy[cidx]};
		end else begin
			err_n = 1'b1;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			if (psel & penable & ~pready) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_n;
				pslverr <= err_n;
			end
		end
	end

	// ==========================================
	// recalibrate button sequencing
	wire hold_done = hold_cnt == 32'(HOLD_CYC - 1);
	wire commit = cal_active & cal_done;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			hold_cnt <= 32'h0000_0000;
			btn_d <= 1'b0;
			pend_sw <= SW_RST;
			from_host <= 1'b0;
		end else begin
			btn_d <= btn;
			hold_cnt <= (state == ST_HOLD) ? hold_cnt + 32'h0000_0001 : 32'h0000_0000;
			case (state)
				ST_IDLE: begin
					if (btn_rise) begin
						state <= ST_HOLD;
					end else if (cal_req & out_of_service_mode) begin
						// bus calibration leaves the switches unread
						pend_sw <= act_sw;
						from_host <= 1'b1;
						state <= ST_CAL;
					end
				end
				ST_HOLD: begin
					if (!btn) begin
						state <= ST_IDLE;
					end else if (hold_done) begin
						if (out_of_service_mode) begin
							pend_sw <= sw_now;
							from_host <= 1'b0;
							state <= ST_CALH;
						end else begin
							state <= ST_REL;
						end
					end
				end
				ST_CALH: begin
					if (cal_done) begin
						state <= ST_REL;
					end else if (!btn) begin
						state <= ST_CAL;
					end
				end
				ST_CAL: begin
					if (cal_done) begin
						state <= ST_IDLE;
					end else if (btn_rise) begin
						// abort: pending copy is dropped
						state <= ST_REL;
					end
				end
				default: begin
					if (!btn) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================
	// active configuration; switch copy frozen between presses
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			act_sw <= SW_RST;
			curve_sel <= CRV_EQP;
			host_ovr <= 1'b0;
			out_of_service_mode <= 1'b0;
			cmd <= 16'h0000;
			resp_q <= 8'h00;
			fail_q <= 1'b0;
		end else begin
			if (commit) begin
				act_sw <= pend_sw;
				resp_q <= resp_param;
				fail_q <= cal_fail;
				if (!from_host) begin
					host_ovr <= 1'b0;
				end
			end
			if (wr & hit_cfg) begin
				// host values win until the next local press commits
				act_sw[CFG_JOG:0] <= pwdata[CFG_JOG:0];
				curve_sel <= pwdata[CFG_CURVE+:2];
				host_ovr <= 1'b1;
			end
			if (wr & hit_ctrl) begin
				out_of_service_mode <= pwdata[CTRL_OOS];
			end
			if (wr & hit_cmd) begin
				cmd <= pwdata[15:0];
			end
		end
	end

	// ==========================================
	// custom curve storage
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NPTS; i++) begin
				cx[i] <= 16'(i * PT_STEP);
			end
			cy <= CUST_RST;
		end else if (wr & hit_cust) begin
			cx[cidx] <= pwdata[31:16];
			cy[cidx] <= pwdata[15:0];
		end
	end

	// ==========================================
	// curve point selection; linear is a straight table
	wire [1:0] mode = act_sw[CFG_OTHER] ? curve_sel : CRV_LIN;
	wire [15:0] cmd_c = (cmd > CMD_MAX) ? CMD_MAX : cmd;
	logic [15:0] xs [NPTS];
	logic [15:0] ys [NPTS];
	for (genvar g = 0; g < NPTS; g++) begin : g_pts
		assign xs[g] = (mode == CRV_CUST) ? cx[g] : 16'(g * PT_STEP);
		assign ys[g] = (mode == CRV_EQP) ? EQP_TBL[g] :
			(mode == CRV_QO) ? QO_TBL[g] :
			(mode == CRV_CUST) ? cy[g] : 16'(g * PT_STEP);
	end
	logic [4:0] seg;
	always_comb begin
		seg = 5'h00;
		for (int i = 1; i < NPTS - 1; i++) begin
			if (cmd_c >= xs[i]) begin
				seg = 5'(i);
			end
		end
	end
	wire [15:0] x0 = xs[seg];
	wire [15:0] dx = xs[seg + 5'h01] - x0;
	wire [15:0] dy = (ys[seg + 5'h01] >= ys[seg]) ? ys[seg + 5'h01] - ys[seg] : 16'h0000;
	wire [15:0] dc = (cmd_c >= x0) ? cmd_c - x0 : 16'h0000;
	wire [31:0] prod = dy * dc;

	// ==========================================
	// interpolation divider; serial to keep area small, 29 cycle refresh
	logic busy;
	logic [4:0] bit_cnt;
	logic [26:0] num;
	logic [15:0] den, ybase;
	logic [16:0] rem;
	wire [16:0] rem_sh = {rem[15:0], num[26]};
	wire q_bit = rem_sh >= {1'b0, den};
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			bit_cnt <= 5'h00;
			num <= 27'h000_0000;
			den <= 16'h0001;
			ybase <= 16'h0000;
			rem <= 17'h0_0000;
			target_pos <= 16'h0000;
		end else if (!busy) begin
			busy <= 1'b1;
			bit_cnt <= 5'h00;
			num <= (dx == 16'h0000) ? 27'h000_0000 : prod[26:0];
			den <= (dx == 16'h0000) ? 16'h0001 : dx;
			ybase <= ys[seg];
			rem <= 17'h0_0000;
		end else if (bit_cnt == 5'd27) begin
			busy <= 1'b0;
			target_pos <= ybase + num[15:0];
		end else begin
			bit_cnt <= bit_cnt + 5'h01;
			rem <= q_bit ? rem_sh - {1'b0, den} : rem_sh;
			num <= {num[25:0], q_bit};
		end
	end

	// ==========================================
	// gain, direction, variant and lamps
	wire [11:0] auto_prod = resp_q * AUTO_SCALE[gain_sel];
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			control_gain <= 10'h000;
			air_to_close <= 1'b0;
			high_friction_mode <= 1'b0;
			cal_active <= 1'b0;
			cal_jog <= 1'b0;
			ff_option <= 2'b00;
			led_green <= 1'b0;
			led_yellow <= 1'b0;
			led_red <= 1'b0;
		end else begin
			// scale E is unity: the standard set from measured response
			control_gain <= act_sw[CFG_AUTO] ? {1'b0, auto_prod[11:3]}
				: PRESET_GAIN[gain_sel];
			air_to_close <= act_sw[CFG_ATC];
			high_friction_mode <= act_sw[CFG_STAB];
			cal_active <= (state == ST_CALH) | (state == ST_CAL);
			cal_jog <= act_sw[CFG_JOG];
			ff_option <= act_sw[CFG_FF+:2];
			led_green <= ~cal_active & ~fail_q;
			led_yellow <= cal_active;
			led_red <= ~cal_active & fail_q;
		end
	end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// testbench
module tb import pcc_pkg::*;;
	localparam int HOLD = 20;
	logic sys_clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic recalibrate_button = 1'h0, fail_req = 1'h0, rerr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic [7:0] cfg_switch_pin = 8'h00, resp_req = 8'h40, resp_param;
	logic [2:0] gain_select_pin = 3'h4;
	logic pready, pslverr, cal_done, cal_fail, air_to_close, high_friction_mode, cal_active;
	logic cal_jog, led_green, led_yellow, led_red;
	logic [1:0] ff_option;
	logic [15:0] target_pos;
	logic [9:0] control_gain;
	int num_errors = 0, total_checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	pcc_top #(.HOLD_CYC(HOLD)) DUT (.sys_clk, .arst_n, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .cfg_switch_pin, .gain_select_pin,
		.recalibrate_button, .cal_done, .cal_fail, .resp_param, .air_to_close,
		.high_friction_mode, .cal_active, .cal_jog, .ff_option, .target_pos, .control_gain,
		.led_green, .led_yellow, .led_red);
	pcc_cal_eng #(.DLY(60)) u_eng (.sys_clk, .cal_active, .fail_req, .resp_req, .cal_done,
		.cal_fail, .resp_param);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		@(posedge sys_clk);
		while (pready !== 1'h1)
			@(posedge sys_clk);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task press(input int n);
		@(posedge sys_clk);
		recalibrate_button <= 1'h1;
		cyc(n);
		recalibrate_button <= 1'h0;
	endtask
	task crv(input logic [31:0] cfg, input logic [31:0] cmd, output logic [15:0] tp);
		apb(1'h1, ADDR_CFG, cfg);
		apb(1'h1, ADDR_CMD, cmd);
		cyc(70); // more than two refresh periods of 29
		tp = target_pos;
	endtask
	task t_regs;
		cfg_switch_pin <= 8'hA5;
		gain_select_pin <= 3'h6;
		cyc(8);
		apb(1'h0, ADDR_SW, 32'h0);
		chk(rd, 32'h6A5);
		apb(1'h0, 12'h020, 32'h0);
		chk(rerr, 1'h1);
		apb(1'h1, ADDR_CFG, 32'h0);
		for (int i = 0; i < 8; i++) begin
			gain_select_pin <= 3'(i);
			cyc(10);
			chk(control_gain, PRESET_GAIN[i]);
		end
		$display("regs done");
	endtask
	task t_curve;
		logic [15:0] tp;
		crv(32'h002, 32'h1388, tp);
		chk(tp, 16'h05D4);
		crv(32'h102, 32'h1388, tp);
		chk(tp, 16'h2508);
		crv(32'h102, 32'h0BB8, tp);
		chk(tp, 16'h2328);
		crv(32'h202, 32'h1388, tp);
		chk(tp, 16'h16D7);
		crv(32'h202, 32'h00FA, tp);
		chk(tp, 16'h01B1);
		apb(1'h1, ADDR_CUST + 12'h004, 32'h01F4_07D0);
		crv(32'h202, 32'h00FA, tp);
		chk(tp, 16'h03E8);
		crv(32'h200, 32'h1388, tp);
		chk(tp, 16'h1388);
		crv(32'h000, 32'hFFFF, tp);
		chk(tp, 16'h2710);
		$display("curve done");
	endtask
	task t_recal;
		apb(1'h1, ADDR_CTRL, 32'h1);
		cfg_switch_pin <= 8'hDD;
		gain_select_pin <= 3'h4;
		cyc(10);
		chk(air_to_close, 1'h0);
		press(HOLD + 10);
		chk(cal_active, 1'h1);
		cyc(80);
		chk(air_to_close, 1'h1);
		chk(high_friction_mode, 1'h1);
		chk(control_gain, 10'h040);
		chk(cal_jog, 1'h1);
		chk(ff_option, 2'h3);
		chk(led_green, 1'h1);
		gain_select_pin <= 3'h5;
		cyc(10);
		chk(control_gain, 10'h050);
		gain_select_pin <= 3'h3;
		cyc(10);
		chk(control_gain, 10'h038);
		cfg_switch_pin <= 8'h00;
		cyc(10);
		chk(air_to_close, 1'h1);
		$display("recal done");
	endtask
	task t_abort;
		apb(1'h1, ADDR_CTRL, 32'h0);
		press(HOLD + 10);
		chk(cal_active, 1'h0);
		apb(1'h1, ADDR_CTRL, 32'h1);
		press(HOLD + 10);
		cyc(4);
		press(6);
		cyc(6);
		chk(cal_active, 1'h0);
		chk(air_to_close, 1'h1);
		$display("abort done");
	endtask
	task t_host;
		apb(1'h1, ADDR_CFG, 32'h0);
		cfg_switch_pin <= 8'h09;
		fail_req <= 1'h1;
		apb(1'h1, ADDR_CTRL, 32'h3);
		cyc(4);
		chk(led_yellow, 1'h1);
		cyc(80);
		chk(air_to_close, 1'h0);
		chk(high_friction_mode, 1'h0);
		chk(led_red, 1'h1);
		chk(led_green, 1'h0);
		$display("host done");
	endtask
	initial begin
		cyc(4);
		arst_n <= 1'h1;
		cyc(5);
		t_regs;
		t_curve;
		t_recal;
		t_abort;
		t_host;
		finish_test;
	end
	// whole run is about a thousand cycles
	initial begin
		cyc(20000);
		num_errors++;
		finish_test;
	end
endmodule
`default_nettype wire
